// *** verilog/cocal_pkg.sv ***
// constants and types shared by the calibration engine files
package cocal_pkg;
   // ----------------------------------------
   // data formats
   // ----------------------------------------
   localparam int DW        = 24;
   localparam int GAIN_FRAC = 22;
   localparam int HPF_SHIFT = 10;
   localparam logic [DW-1:0] SMP_MAX     = 24'h7F_FFFF;
   localparam logic [DW-1:0] SMP_MIN     = 24'h80_0000;
   localparam logic [DW-1:0] GAIN_ONE    = 24'h40_0000;
   localparam logic [DW-1:0] GAIN_MAX    = 24'hFF_FFFF;
   localparam logic [DW-1:0] DC_GAIN_NUM = 24'h80_0000;
   localparam logic [DW-1:0] AC_GAIN_NUM = 24'h4C_CCCC;
   // ----------------------------------------
   // timing in conversions
   // ----------------------------------------
   localparam int SETTLE_CONV = 30;
   localparam int AC_MULT     = 6;
   // ----------------------------------------
   // register map, byte addresses
   // ----------------------------------------
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_CFG   = 8'h04;
   localparam logic [7:0] A_CYC   = 8'h08;
   localparam logic [7:0] A_STAT  = 8'h0C;
   localparam logic [7:0] A_MASK  = 8'h10;
   localparam logic [7:0] A_DCOFF = 8'h14;
   localparam logic [7:0] A_GAIN  = 8'h1C;
   localparam logic [7:0] A_ACOFF = 8'h24;
   localparam logic [7:0] A_LAST  = 8'h28;
   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int CTRL_START = 0;
   localparam int CTRL_TYPE  = 1;
   localparam int CTRL_CH    = 3;
   localparam int CFG_HPF    = 0;
   localparam int ST_DONE    = 0;
   localparam int ST_BUSY    = 1;
   localparam int ST_INVAL   = 2;
   localparam logic [DW-1:0] CYC_RST  = 24'h00_0FA0;
   localparam logic [2:0]    MASK_RST = 3'h0;
   typedef enum logic [1:0] {
      CAL_DC_OFF  = 2'b00,
      CAL_AC_OFF  = 2'b01,
      CAL_DC_GAIN = 2'b10,
      CAL_AC_GAIN = 2'b11
   } cocal_type_t;
endpackage

// *** verilog/cocal_chan_if.sv ***
// per-channel correction signals between engine and datapath
`timescale 1ns/1ns
interface cocal_chan_if;
   import cocal_pkg::*;
   logic signed [DW-1:0] raw;
   logic signed [DW-1:0] dc_off;
   logic signed [DW-1:0] smp;
   logic        [DW-1:0] rms_raw;
   logic        [DW-1:0] gain;
   logic        [DW-1:0] ac_off;
   logic        [DW-1:0] rms;
   logic                 hpf_en;
   modport ctl (output raw, rms_raw, dc_off, gain, ac_off, hpf_en, input smp, rms);
   modport cor (input raw, rms_raw, dc_off, gain, ac_off, hpf_en, output smp, rms);
endinterface

// *** verilog/cocal_div.sv ***
// sequential unsigned restoring divider
`timescale 1ns/1ns
module cocal_div #(
   parameter int W = 64
) (
   input  wire logic         pclk,    // clock
   input  wire logic         presetn, // async reset
   input  wire logic         ce,      // clock enable
   input  wire logic         start,   // begin division
   input  wire logic [W-1:0] num,     // dividend
   input  wire logic [W-1:0] den,     // divisor
   output logic              done,    // quotient valid pulse
   output logic      [W-1:0] quo      // quotient
);
   localparam int CW = $clog2(W + 1);
   if (W < 8) begin : g_chk
      $error("cocal_div: W too small");
   end
   logic [W-1:0]  r;
   logic [CW-1:0] cnt;
   logic          run;
   logic [W-1:0]  sh;
   logic [W:0]    tr;
   assign sh = {r[W-2:0], quo[W-1]};
   assign tr = {1'b0, sh} - {1'b0, den};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quo  <= '0;
         r    <= '0;
         cnt  <= '0;
         run  <= 1'b0;
         done <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start) begin
            quo <= num;
            r   <= '0;
            cnt <= CW'(W);
            run <= 1'b1;
         end else if (run) begin
            quo <= {quo[W-2:0], ~tr[W]};
            r   <= tr[W] ? sh : tr[W-1:0];
            cnt <= cnt - 1'b1;
            if (cnt == CW'(1)) begin
               run  <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule

// *** verilog/cocal_corr.sv ***
// per-channel sample and rms correction datapath
`timescale 1ns/1ns
module cocal_corr
   import cocal_pkg::*;
(
   input  wire logic  pclk,    // clock
   input  wire logic  presetn, // async reset
   input  wire logic  ce,      // clock enable
   input  wire logic  stb,     // new conversion result
   cocal_chan_if.cor  ch       // channel signals
);
   logic signed [DW-1:0]     mean;
   logic signed [DW+1:0]     hp;
   logic signed [DW+1:0]     ofs;
   logic signed [2*DW+2:0]   prod;
   logic        [DW:0]       rdif;
   logic        [DW-GAIN_FRAC+3:0] top;
   always_comb begin
      // running mean removal when the filter is on
      hp   = {{2{ch.raw[DW-1]}}, ch.raw} - (ch.hpf_en ? {{2{mean[DW-1]}}, mean} : '0); // RULE22
      ofs  = hp + {{2{ch.dc_off[DW-1]}}, ch.dc_off};                                // RULE7
      prod = ofs * $signed({1'b0, ch.gain});                                         // RULE11
      top  = prod[2*DW+2:GAIN_FRAC+DW-1];
      rdif = {1'b0, ch.rms_raw} - {1'b0, ch.ac_off};                                 // RULE9
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mean   <= '0;
         ch.smp <= '0;
         ch.rms <= '0;
      end else if (ce && stb) begin
         mean <= ch.hpf_en ? mean + DW'(hp >>> HPF_SHIFT) : '0;
         if (top == '0 || top == '1) begin
            ch.smp <= prod[GAIN_FRAC+DW-1:GAIN_FRAC];
         end else begin
            ch.smp <= prod[2*DW+2] ? SMP_MIN : SMP_MAX;
         end
         ch.rms <= rdif[DW] ? '0 : rdif[DW-1:0];
      end
   end
endmodule

// *** verilog/cocal_top.sv ***
// offset and gain calibration engine with apb registers
// Contract
// RULE1: on finish store result in channel register and set done flag
// RULE2: done flag reaches interrupt output only when its mask bit is set
// RULE3: dc offset and gain calibrations take at least N+30 conversions
// RULE4: ac offset calibration takes at least 6N+30 conversions
// RULE5: cycle count N sets the number of conversions accumulated
// RULE6: dc offset calibration stores the negated sample average
// RULE7: stored dc offset is added to every sample; the code holds a channel's own offset out during its dc offset calibration
// RULE8: ac offset calibration stores the channel rms level
// RULE9: stored ac offset is subtracted from every rms result
// RULE10: ac gain calibration stores 0.6 divided by measured rms
// RULE11: every sample is multiplied by the channel gain
// RULE12: dc gain calibration first resets the gain to unity
// RULE13: dc gain calibration stores 1.0 divided by sample average
// RULE14: gain never exceeds 4; larger result is flagged invalid
// RULE15: each channel keeps its own offset and gain registers
// RULE16: calibration works on values already corrected by current registers; dc offset calibration holds the channel's own dc offset out
// RULE17: host issues commands only while the device is active
// RULE18: host zeroes ac offsets before any offset calibration
// RULE19: host sets gain to unity before dc offset calibration
// RULE20: host prefers ac gain calibration when gain is not unity
// RULE21: host keeps the high-pass filter off with dc gain calibration
// RULE22: high-pass filter option removes dc from the signal path
// RULE23: command selects type and channels; host waits for done
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
module cocal_top
   import cocal_pkg::*;
#(
   parameter int CNT_W = 24,
   parameter int DIV_W = 64
) (
   input  wire logic                pclk,      // clock
   input  wire logic                presetn,   // async reset
   input  wire logic                ce,        // clock enable
   input  wire logic                psel,      // apb select
   input  wire logic                penable,   // apb enable
   input  wire logic                pwrite,    // apb write
   input  wire logic [7:0]          paddr,     // apb address
   input  wire logic [31:0]         pwdata,    // apb write data
   output logic      [31:0]         prdata,    // apb read data
   output logic                     pready,    // apb ready
   output logic                     pslverr,   // apb error
   input  wire logic                smp_valid, // conversion strobe
   input  wire logic signed [DW-1:0] v_raw,    // voltage sample
   input  wire logic signed [DW-1:0] i_raw,    // current sample
   input  wire logic [DW-1:0]       v_rms_raw, // voltage rms
   input  wire logic [DW-1:0]       i_rms_raw, // current rms
   output logic signed [DW-1:0]     v_smp,     // corrected voltage
   output logic signed [DW-1:0]     i_smp,     // corrected current
   output logic      [DW-1:0]       v_rms,     // corrected voltage rms
   output logic      [DW-1:0]       i_rms,     // corrected current rms
   output logic                     cal_irq    // interrupt request
);
   localparam int TW = CNT_W + 3;
   localparam int SW = DW + CNT_W + 4;
   if (CNT_W < 1 || CNT_W > DW || DIV_W < SW || DIV_W < DW + GAIN_FRAC + 2) begin : g_chk
      $error("cocal_top: unsupported widths");
   end

   // ----------------------------------------
   // state and registers
   // ----------------------------------------
   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_SETTLE = 3'b001,
      S_ACCUM  = 3'b010,
      S_AVG    = 3'b011,
      S_QUO    = 3'b100,
      S_STORE  = 3'b101
   } cocal_st_t;

   cocal_st_t            st;
   cocal_type_t          ctype;
   logic [1:0]           chsel;
   logic                 cur;
   logic                 wt;
   logic                 neg;
   logic                 hpf;
   logic [2:0]           mask;
   logic                 done_flag;
   logic                 inval;
   logic [DW-1:0]        cyc;
   logic [TW-1:0]        cnt;
   logic [TW-1:0]        target;
   logic [DW-1:0]        avg;
   logic [DW-1:0]        res;
   logic signed [DW-1:0] dc_off [2];
   logic [DW-1:0]        gain   [2];
   logic [DW-1:0]        ac_off [2];
   logic signed [SW-1:0] sum    [2];
   logic signed [DW-1:0] raw_a  [2];
   logic [DW-1:0]        rraw_a [2];
   logic signed [DW-1:0] smp_a  [2];
   logic [DW-1:0]        rms_a  [2];
   logic [SW-1:0]        abs_s;
   logic [DW-1:0]        gnum;
   logic [DIV_W-1:0]     d_num;
   logic [DIV_W-1:0]     d_den;
   logic [DIV_W-1:0]     d_quo;
   logic                 d_start;
   logic                 d_done;
   logic                 wr;
   logic                 go;
   logic                 fin;
   logic [31:0]          rd_data;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   function automatic logic addr_hit(input logic [7:0] a);
      return (a <= A_LAST) && (a[1:0] == 2'b00);
   endfunction

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_hit(paddr);
   assign wr      = psel && penable && pwrite && addr_hit(paddr);
   // a command is taken only when idle and naming a channel
   assign go  = wr && paddr == A_CTRL && pwdata[CTRL_START] && st == S_IDLE
                && pwdata[CTRL_CH +: 2] != 2'b00;                              // RULE23
   assign fin = st == S_STORE && !(cur == 1'b0 && chsel[1]);

   always_comb begin
      rd_data = '0;
      unique case (paddr)
         A_CTRL:        rd_data = {27'h000_0000, chsel, ctype, st != S_IDLE};
         A_CFG:         rd_data[CFG_HPF] = hpf;
         A_CYC:         rd_data[DW-1:0] = cyc;
         A_STAT:        rd_data[2:0] = {inval, st != S_IDLE, done_flag};
         A_MASK:        rd_data[2:0] = mask;
         A_DCOFF:       rd_data[DW-1:0] = dc_off[0];
         A_DCOFF + 8'h04: rd_data[DW-1:0] = dc_off[1];
         A_GAIN:        rd_data[DW-1:0] = gain[0];
         A_GAIN + 8'h04: rd_data[DW-1:0] = gain[1];
         A_ACOFF:       rd_data[DW-1:0] = ac_off[0];
         A_ACOFF + 8'h04: rd_data[DW-1:0] = ac_off[1];
         default:       rd_data = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (ce && psel && !penable) begin
         prdata <= rd_data;
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hpf  <= 1'b0;
         mask <= MASK_RST;
         cyc  <= CYC_RST;
      end else if (ce && wr) begin
         if (paddr == A_CFG) begin
            hpf <= pwdata[CFG_HPF];
         end
         if (paddr == A_MASK) begin
            mask <= pwdata[2:0];
         end
         if (paddr == A_CYC) begin
            cyc <= pwdata[DW-1:0];
         end
      end
   end

   // ----------------------------------------
   // status flags, set wins over clear
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_flag <= 1'b0;
         inval     <= 1'b0;
         cal_irq   <= 1'b0;
      end else if (ce) begin
         if (fin) begin
            done_flag <= 1'b1;                                                  // RULE1
         end else if (wr && paddr == A_STAT && pwdata[ST_DONE]) begin
            done_flag <= 1'b0;
         end
         if (st == S_QUO && d_done && wt && |d_quo[DIV_W-1:DW]) begin
            inval <= 1'b1;                                                      // RULE14
         end else if (wr && paddr == A_STAT && pwdata[ST_INVAL]) begin
            inval <= 1'b0;
         end
         cal_irq <= |({inval, 1'b0, done_flag} & mask);                         // RULE2
      end
   end

   // ----------------------------------------
   // correction registers, one set per channel
   // ----------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_reg
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            dc_off[g] <= '0;
            gain[g]   <= GAIN_ONE;
            ac_off[g] <= '0;
         end else if (ce) begin
            if (go && pwdata[CTRL_CH+g] && pwdata[CTRL_TYPE +: 2] == CAL_DC_GAIN) begin
               gain[g] <= GAIN_ONE;                                             // RULE12
            end else if (st == S_STORE && cur == 1'(g)) begin                   // RULE15
               unique case (ctype)
                  CAL_DC_OFF:  dc_off[g] <= neg ? avg : -avg;                   // RULE6
                  CAL_AC_OFF:  ac_off[g] <= avg;                                // RULE8
                  CAL_DC_GAIN: gain[g]   <= res;                                // RULE13
                  CAL_AC_GAIN: gain[g]   <= res;                                // RULE10
               endcase
            end else if (wr) begin
               if (paddr == A_DCOFF + 8'(4 * g)) begin
                  dc_off[g] <= pwdata[DW-1:0];
               end
               if (paddr == A_GAIN + 8'(4 * g)) begin
                  gain[g] <= pwdata[DW-1:0];
               end
               if (paddr == A_ACOFF + 8'(4 * g)) begin
                  ac_off[g] <= pwdata[DW-1:0];
               end
            end
         end
      end
   end

   // ----------------------------------------
   // channel datapaths
   // ----------------------------------------
   cocal_chan_if chif [2] ();

   assign raw_a[0]  = v_raw;
   assign raw_a[1]  = i_raw;
   assign rraw_a[0] = v_rms_raw;
   assign rraw_a[1] = i_rms_raw;

   for (genvar g = 0; g < 2; g++) begin : g_ch
      assign chif[g].raw     = raw_a[g];
      assign chif[g].rms_raw = rraw_a[g];
      // own offset held out while it is being measured
      assign chif[g].dc_off  = (st != S_IDLE && ctype == CAL_DC_OFF && chsel[g]) ? '0 : dc_off[g]; // RULE6
      assign chif[g].gain    = gain[g];
      assign chif[g].ac_off  = ac_off[g];
      assign chif[g].hpf_en  = hpf;
      assign smp_a[g]        = chif[g].smp;
      assign rms_a[g]        = chif[g].rms;
      cocal_corr u_corr (
         .pclk    (pclk),
         .presetn (presetn),
         .ce      (ce),
         .stb     (smp_valid),
         .ch      (chif[g])
      );
   end

   assign v_smp = chif[0].smp;
   assign i_smp = chif[1].smp;
   assign v_rms = chif[0].rms;
   assign i_rms = chif[1].rms;

   // ----------------------------------------
   // divider shared by both channels
   // ----------------------------------------
   assign abs_s   = sum[cur][SW-1] ? SW'(-sum[cur]) : SW'(sum[cur]);
   assign gnum    = ctype == CAL_AC_GAIN ? AC_GAIN_NUM : DC_GAIN_NUM;           // RULE10
   assign d_start = (st == S_AVG || st == S_QUO) && !wt;
   assign d_num   = st == S_AVG ? DIV_W'(abs_s) : DIV_W'({gnum, {GAIN_FRAC{1'b0}}}); // RULE13
   assign d_den   = st == S_AVG ? DIV_W'(target) : DIV_W'(avg);

   cocal_div #(.W(DIV_W)) u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .start   (d_start),
      .num     (d_num),
      .den     (d_den),
      .done    (d_done),
      .quo     (d_quo)
   );

   // ----------------------------------------
   // calibration sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st     <= S_IDLE;
         ctype  <= CAL_DC_OFF;
         chsel  <= 2'b00;
         cur    <= 1'b0;
         wt     <= 1'b0;
         neg    <= 1'b0;
         cnt    <= '0;
         target <= '0;
         avg    <= '0;
         res    <= '0;
         sum    <= '{default: '0};
      end else if (ce) begin
         unique case (st)
            S_IDLE: begin
               if (go) begin
                  ctype  <= cocal_type_t'(pwdata[CTRL_TYPE +: 2]);
                  chsel  <= pwdata[CTRL_CH +: 2];
                  cnt    <= '0;
                  sum    <= '{default: '0};
                  target <= pwdata[CTRL_TYPE +: 2] == CAL_AC_OFF
                            ? TW'(AC_MULT) * TW'(cyc[CNT_W-1:0] | CNT_W'(cyc[CNT_W-1:0] == '0)) // RULE4
                            : TW'(cyc[CNT_W-1:0] | CNT_W'(cyc[CNT_W-1:0] == '0));  // RULE5
                  st     <= S_SETTLE;
               end
            end
            S_SETTLE: begin
               if (smp_valid) begin
                  cnt <= cnt + 1'b1;
                  if (cnt == TW'(SETTLE_CONV - 1)) begin                        // RULE3
                     cnt <= '0;
                     st  <= S_ACCUM;
                  end
               end
            end
            S_ACCUM: begin
               if (smp_valid) begin
                  for (int k = 0; k < 2; k++) begin
                     // inputs carry the current corrections, except an own dc offset held out during dc offset calibration
                     if (ctype == CAL_AC_OFF || ctype == CAL_AC_GAIN) begin
                        sum[k] <= sum[k] + SW'(rms_a[k]);                       // RULE16
                     end else begin
                        sum[k] <= sum[k] + SW'(smp_a[k]);                       // RULE16
                     end
                  end
                  cnt <= cnt + 1'b1;
                  if (cnt == target - 1'b1) begin
                     cur <= !chsel[0];
                     st  <= S_AVG;
                  end
               end
            end
            S_AVG: begin
               if (!wt) begin
                  wt  <= 1'b1;
                  neg <= sum[cur][SW-1];
               end else if (d_done) begin
                  wt  <= 1'b0;
                  avg <= d_quo[DW-1:0];
                  st  <= ctype[1] ? S_QUO : S_STORE;
               end
            end
            S_QUO: begin
               if (!wt) begin
                  wt <= 1'b1;
               end else if (d_done) begin
                  wt  <= 1'b0;
                  res <= |d_quo[DIV_W-1:DW] ? GAIN_MAX : d_quo[DW-1:0];         // RULE14
                  st  <= S_STORE;
               end
            end
            S_STORE: begin
               if (cur == 1'b0 && chsel[1]) begin
                  cur <= 1'b1;
                  st  <= S_AVG;
               end else begin
                  st <= S_IDLE;                                                 // RULE1
               end
            end
            default: st <= S_IDLE;
         endcase
      end
   end
endmodule

// *** tb/cocal_front.sv ***
// conversion pacer standing in for the modulators
`timescale 1ns/1ns
module cocal_front (
   input  wire logic pclk,     // clock
   input  wire logic presetn,  // reset
   output logic      smp_valid // strobe
);
   logic [1:0] div;
   // one conversion every fourth clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) div <= 2'h0;
      else div <= div + 2'h1;
   end
   assign smp_valid = div == 2'h3;
endmodule

// *** tb/cocal_top_properties.sv ***
// port checker for the calibration engine
`timescale 1ns/1ns
module cocal_props
   import cocal_pkg::*;
(
   input wire logic                 pclk,      // clock
   input wire logic                 presetn,   // reset
   input wire logic                 ce,        // enable
   input wire logic                 psel,      // select
   input wire logic                 penable,   // access
   input wire logic                 pwrite,    // write
   input wire logic [7:0]           paddr,     // address
   input wire logic [31:0]          pwdata,    // data
   input wire logic                 smp_valid, // strobe
   input wire logic signed [DW-1:0] v_smp,     // v out
   input wire logic signed [DW-1:0] i_smp,     // i out
   input wire logic                 cal_irq    // irq
);
   logic        wr;
   logic [31:0] cnt, cyc, need;
   logic [2:0]  mask_q;
   assign wr = psel && penable && pwrite && ce;
   // strobes since the last start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt <= 32'h0000_0000;
      else if (wr && paddr == A_CTRL && pwdata[0]) cnt <= 32'h0000_0000;
      else if (smp_valid && ce) cnt <= cnt + 32'h0000_0001;
   end
   // shadow of count, mask and minimum sequence length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc    <= {8'h00, CYC_RST};
         mask_q <= MASK_RST;
         need   <= 32'h0000_0000;
      end else if (wr) begin
         if (paddr == A_CYC) cyc <= {8'h00, pwdata[23:0]};
         if (paddr == A_MASK) mask_q <= pwdata[2:0];
         if (paddr == A_CTRL && pwdata[0]) need <= (pwdata[2:1] == 2'b01 ? AC_MULT : 1) * cyc + SETTLE_CONV;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   v_hold_a: assert property (!smp_valid |=> $stable(v_smp)) else $error("v_smp moved");
   i_hold_a: assert property (!smp_valid |=> $stable(i_smp)) else $error("i_smp moved");
   irq_mask_a: assert property (cal_irq |-> ($past(mask_q) & 3'h5) != 3'h0) else $error("irq unmasked");
   mask_off_a: assert property (wr && paddr == A_MASK && pwdata[2:0] == 3'h0 |-> ##2 !cal_irq) else $error("irq kept");
   irq_hold_a: assert property (cal_irq && !wr && !$past(wr) |=> cal_irq) else $error("irq dropped");
   irq_clear_a: assert property (wr && paddr == A_STAT && pwdata[2:0] == 3'h5 |-> ##2 !cal_irq) else $error("irq stuck");
   dc_len_a: assert property ($rose(cal_irq) |-> cnt >= cyc + SETTLE_CONV) else $error("too short");
   ac_len_a: assert property ($rose(cal_irq) |-> cnt >= need) else $error("ac too short");
endmodule
bind cocal_top cocal_props u_props (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
   .smp_valid, .v_smp, .i_smp, .cal_irq);

// *** tb/cocal_top_bench.sv ***
// self-checking bench for the calibration engine
`timescale 1ns/1ns
module cocal_top_bench;
   import cocal_pkg::*;
   logic                 pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic                 smp_valid, pready, pslverr, cal_irq, err_q;
   logic [7:0]           paddr = '0;
   logic [31:0]          pwdata = '0, prdata, rd_q;
   logic signed [DW-1:0] v_raw = '0, i_raw = '0, v_smp, i_smp;
   logic [DW-1:0]        v_rms_raw = '0, i_rms_raw = '0, v_rms, i_rms;
   int                   n_errors = 0, checks_done = 0;
   cocal_front u_front (.pclk, .presetn, .smp_valid);
   cocal_top u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .smp_valid, .v_raw, .i_raw, .v_rms_raw, .i_rms_raw, .v_smp, .i_smp, .v_rms, .i_rms, .cal_irq);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_q    = prdata;
      err_q   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0000_0000);
      chk(rd_q, exp);
   endtask
   task automatic cal(input logic [31:0] ctrl, input logic [31:0] st);
      apb(A_CTRL, 1'b1, ctrl);
      repeat (3000) if (cal_irq !== 1'b1) @(posedge pclk);
      chk(cal_irq, 1'b1);
      rd(A_STAT, st);
      apb(A_STAT, 1'b1, 32'h0000_0005);
      @(posedge pclk);
      chk(cal_irq, 1'b0);
   endtask
   task automatic t_regs;
      rd(A_STAT, 32'h0000_0000);
      rd(A_CYC, 32'h0000_0FA0);
      rd(A_GAIN, 32'h0040_0000);
      rd(8'h2C, 32'h0000_0000);
      chk(err_q, 1'b1);
      apb(A_CYC, 1'b1, 32'h0000_0002);
      apb(A_MASK, 1'b1, 32'h0000_0000);
      apb(A_MASK, 1'b1, 32'h0000_0001);
   endtask
   task automatic t_dc;
      v_raw <= 24'h00_1000;
      i_raw <= 24'h00_2000;
      cal(32'h0000_0009, 32'h0000_0001);
      rd(A_DCOFF, 32'h00FF_F000);
      rd(A_DCOFF + 8'h04, 32'h0000_0000);
      repeat (12) @(posedge pclk);
      chk(v_smp, 24'h00_0000);
      chk(i_smp, 24'h00_2000);
   endtask
   task automatic t_gain;
      i_raw <= 24'h10_0000;
      cal(32'h0000_0015, 32'h0000_0005);
      rd(A_GAIN + 8'h04, 32'h00FF_FFFF);
      i_raw <= 24'h40_0000;
      cal(32'h0000_0015, 32'h0000_0001);
      rd(A_GAIN + 8'h04, 32'h0080_0000);
      rd(A_GAIN, 32'h0040_0000);
      repeat (12) @(posedge pclk);
      chk(i_smp, 24'h7F_FFFF);
   endtask
   task automatic t_ac;
      v_rms_raw <= 24'h00_0100;
      i_rms_raw <= 24'h40_0000;
      apb(A_ACOFF, 1'b1, 32'h0000_0000);
      cal(32'h0000_000B, 32'h0000_0001);
      rd(A_ACOFF, 32'h0000_0100);
      repeat (12) @(posedge pclk);
      chk(v_rms, 24'h00_0000);
      chk(i_rms, 24'h40_0000);
      cal(32'h0000_0017, 32'h0000_0001);
      rd(A_GAIN + 8'h04, 32'h004C_CCCC);
   endtask
   task automatic t_hpf;
      apb(A_CFG, 1'b1, 32'h0000_0001);
      repeat (400) @(posedge pclk);
      checks_done++;
      if ($isunknown(v_smp) || v_smp >= 0 || v_smp <= -24'sh00_1000) begin
         n_errors++;
         $display("ERROR %0t: dc not removed %h", $time, v_smp);
      end
   endtask
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial forever #5 pclk = ~pclk;
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_dc;
      t_gain;
      t_ac;
      t_hpf;
      tally_and_finish;
   end
   initial begin
      #200000 n_errors++;
      tally_and_finish;
   end
endmodule
